/* rtc_bkp_mem.sv */
`timescale 1ns/1ps
module rtc_bkp_mem (
    input wire logic pclk,
    input wire logic we,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    // ------------------------------------------------------------
    // storage, deliberately without any reset
    // ------------------------------------------------------------
    logic [31:0] mem_q [0:rtc_pkg::RTC_NUM_BKP-1];
    logic [31:0] rdata_q;

    always_ff @(posedge pclk) begin
        if (we) begin
            mem_q[addr] <= wdata; // R9 R10
        end
        rdata_q <= mem_q[addr];
    end

    assign rdata = rdata_q;
endmodule

/* rtc_cal.sv */
`timescale 1ns/1ps
module rtc_cal (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic fmt12,
    input wire logic ld_time,
    input wire logic ld_date,
    input wire logic [31:0] wdata,
    rtc_cal_if.cal c
);
    logic [7:0] s_q, s_d, mi_q, mi_d, h_q, h_d;
    logic [7:0] d_q, d_d, mo_q, mo_d, y_q, y_d;
    logic [2:0] wd_q, wd_d;
    logic pm_q, pm_d;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // calendar next state
    // ------------------------------------------------------------
    always_comb begin
        logic day;
        day = 1'b0;
        {s_d, mi_d, h_d, pm_d} = {s_q, mi_q, h_q, pm_q};
        {d_d, mo_d, y_d, wd_d} = {d_q, mo_q, y_q, wd_q};
        if (ld_time) begin
            s_d = {1'b0, wdata[6:0]};
            mi_d = {1'b0, wdata[14:8]};
            h_d = {2'b00, wdata[21:16]};
            pm_d = wdata[22] & fmt12; // R1
        end else if (tick) begin
            s_d = bcd_inc(s_q); // R1
            if (s_q == 8'h59) begin
                s_d = 8'h00;
                mi_d = bcd_inc(mi_q);
                if (mi_q == 8'h59) begin
                    mi_d = 8'h00;
                    h_d = bcd_inc(h_q);
                    if (!fmt12 && h_q == 8'h23) begin
                        h_d = 8'h00; // R1
                        day = 1'b1;
                    end
                    if (fmt12 && h_q == 8'h11) begin
                        pm_d = ~pm_q; // R1
                        day = pm_q;
                    end
                    if (fmt12 && h_q == 8'h12) begin
                        h_d = 8'h01;
                    end
                end
            end
        end
        if (ld_date) begin
            d_d = {2'b00, wdata[5:0]};
            mo_d = {3'b000, wdata[12:8]};
            wd_d = wdata[15:13];
            y_d = wdata[23:16];
        end else if (day) begin
            wd_d = (wd_q == 3'h7) ? 3'h1 : wd_q + 3'h1;
            d_d = bcd_inc(d_q);
            if (d_q == month_len(mo_q, y_q)) begin
                d_d = 8'h01; // R2
                mo_d = bcd_inc(mo_q);
                if (mo_q == 8'h12) begin
                    mo_d = 8'h01;
                    y_d = (y_q == 8'h99) ? 8'h00 : bcd_inc(y_q);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= {1'b0, rtc_pkg::RTC_TIME_RST[6:0]};
            mi_q <= {1'b0, rtc_pkg::RTC_TIME_RST[14:8]};
            h_q <= {2'b00, rtc_pkg::RTC_TIME_RST[21:16]};
            pm_q <= rtc_pkg::RTC_TIME_RST[22];
            d_q <= {2'b00, rtc_pkg::RTC_DATE_RST[5:0]};
            mo_q <= {3'b000, rtc_pkg::RTC_DATE_RST[12:8]};
            wd_q <= rtc_pkg::RTC_DATE_RST[15:13];
            y_q <= rtc_pkg::RTC_DATE_RST[23:16];
        end else begin
            {s_q, mi_q, h_q, pm_q} <= {s_d, mi_d, h_d, pm_d};
            {d_q, mo_q, y_q, wd_q} <= {d_d, mo_d, y_d, wd_d};
        end
    end

    assign c.sec = s_q[6:0];
    assign c.min = mi_q[6:0];
    assign c.hour = h_q[5:0];
    assign c.pm = pm_q;
    assign c.date = d_q[5:0];
    assign c.month = mo_q[4:0];
    assign c.wday = wd_q;
    assign c.year = y_q;
endmodule

/* rtc_cal_if.sv */
`timescale 1ns/1ps
interface rtc_cal_if;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic pm;
    logic [5:0] date;
    logic [4:0] month;
    logic [2:0] wday;
    logic [7:0] year;
    modport cal (output sec, min, hour, pm, date, month, wday, year);
    modport rd (input sec, min, hour, pm, date, month, wday, year);
endinterface

/* rtc_pkg.sv */
package rtc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] RTC_TIME = 12'h000;
    localparam logic [11:0] RTC_DATE = 12'h004;
    localparam logic [11:0] RTC_CTRL = 12'h008;
    localparam logic [11:0] RTC_SSR = 12'h00c;
    localparam logic [11:0] RTC_SHIFT = 12'h010;
    localparam logic [11:0] RTC_CAL = 12'h014;
    localparam logic [11:0] RTC_WUTR = 12'h018;
    localparam logic [11:0] RTC_ALRA = 12'h01c;
    localparam logic [11:0] RTC_ALRB = 12'h020;
    localparam logic [11:0] RTC_TSTIME = 12'h024;
    localparam logic [11:0] RTC_TSDATE = 12'h028;
    localparam logic [11:0] RTC_TSSSR = 12'h02c;
    localparam logic [11:0] RTC_STAT = 12'h030;
    localparam logic [11:0] RTC_MASK = 12'h034;
    localparam logic [4:0] RTC_BKP_PAGE = 5'h02;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int RTC_C_INIT = 0;
    localparam int RTC_C_FMT12 = 1;
    localparam int RTC_C_REFON = 2;
    localparam int RTC_C_REF60 = 3;
    localparam int RTC_C_WUTEN = 4;
    localparam int RTC_C_WUCK = 5;
    localparam int RTC_C_ALRAEN = 8;
    localparam int RTC_C_ALRBEN = 9;
    localparam int RTC_C_TSEN = 10;
    localparam int RTC_C_TAMPTS = 11;
    localparam int RTC_C_CKSEL = 12;
    localparam int RTC_C_TAMPEN = 14;
    localparam int RTC_C_TAMPFLT = 17;
    // ------------------------------------------------------------
    // status bits, reset values, counts
    // ------------------------------------------------------------
    localparam int RTC_S_ALRA = 0;
    localparam int RTC_S_ALRB = 1;
    localparam int RTC_S_WUT = 2;
    localparam int RTC_S_TS = 3;
    localparam int RTC_S_TAMP = 4;
    localparam int RTC_NUM_EV = 7;
    localparam int RTC_NUM_TAMP = 3;
    localparam int RTC_NUM_BKP = 32;
    localparam logic [31:0] RTC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RTC_TIME_RST = 32'h0000_0000;
    localparam logic [31:0] RTC_DATE_RST = 32'h0000_2101;
    localparam logic [6:0] RTC_APRE_MAX = 7'h7f;
    localparam logic [7:0] RTC_SPRE_MAX = 8'hff;
    localparam logic [4:0] RTC_HSE_DIV_MAX = 5'h1f;
    localparam int RTC_CAL_W = 20;
    localparam logic [5:0] RTC_REF_50HZ = 6'h32;
    localparam logic [5:0] RTC_REF_60HZ = 6'h3c;
    typedef enum logic [1:0] {
        RTC_CK_LSXTAL = 2'h0,
        RTC_CK_LSRC = 2'h1,
        RTC_CK_HSXTAL = 2'h2
    } rtc_cksel_t;
endpackage

/* rtc_top.sv */
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// R1: BCD calendar, 12 or 24 hour format
// R2: date rolls over by month length, leap years
// R3: shift delays calendar by 1..32767 pulses
// R4: 50/60 Hz reference paces the seconds
// R5: calibration drops pulses, 0.95 ppm steps
// R6: three tamper pins with programmable filter
// R7: timestamp on pin, tamper or battery switch
// R8: 17-bit auto-reload wakeup down-counter
// R9: 32 backup words of 32 bits
// R10: backup words survive every reset
// R11: counting clock from three selectable sources
// R12: source choice limits battery, shutdown running
// R13: events raise interrupt and wakeup request
// R14: alarm matches enabled fields, own flags
module rtc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_speed_crystal_clock_tick,
    input wire logic low_speed_rc_clock_tick,
    input wire logic high_speed_crystal_clock_tick,
    input wire logic on_battery,
    input wire logic in_shutdown,
    input wire logic ref_in,
    input wire logic ts_in,
    input wire logic [2:0] tamper_in,
    output logic irq,
    output logic wakeup_req
);
    rtc_cal_if cal_bus ();

    logic [31:0] ctrl_q, ctrl_d, alra_q, alra_d, alrb_q, alrb_d;
    logic [31:0] tst_q, tst_d, tsd_q, tsd_d, prdata_q, prdata_d;
    logic [7:0] tss_q, tss_d;
    logic [14:0] shift_q, shift_d;
    logic [8:0] calm_q, calm_d;
    logic [15:0] wutr_q, wutr_d;
    logic [6:0] st_q, st_d, mask_q, mask_d, ev;
    logic err_q, err_d, bkp_rd_q, bkp_rd_d;
    logic [4:0] hdiv_q, hdiv_d;
    logic [6:0] a_q, a_d;
    logic [7:0] sp_q, sp_d;
    logic [19:0] win_q, win_d;
    logic [5:0] rcnt_q, rcnt_d;
    logic [16:0] wu_q, wu_d;
    logic [1:0] hit_q, hit_d;
    logic ref_p_q, ts_p_q, bat_p_q;
    logic src, run, p, drop_cal, shift_take, eff, tick, samp, ts_ev;
    logic wu_base, ref_sec;
    logic [2:0] tamp_ev;
    logic [31:0] time_w, date_w, bkp_rdata;
    logic wr, setup, ld_time, ld_date;
    logic [2:0] wuck;
    logic [7:0] ssr;

    function automatic logic is_bkp(input logic [11:0] a);
        is_bkp = (a[11:7] == rtc_pkg::RTC_BKP_PAGE);
    endfunction

    function automatic logic alarm_hit(input logic [31:0] a,
                                       input logic [31:0] t);
        alarm_hit = (a[7] | (a[6:0] == t[6:0]))
                  & (a[15] | (a[14:8] == t[14:8]))
                  & (a[23] | (a[22:16] == t[22:16]))
                  & (a[31] | (a[29:24] == t[29:24]));
    endfunction

    assign wr = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign ld_time = wr & (paddr == rtc_pkg::RTC_TIME)
                     & ctrl_q[rtc_pkg::RTC_C_INIT];
    assign ld_date = wr & (paddr == rtc_pkg::RTC_DATE)
                     & ctrl_q[rtc_pkg::RTC_C_INIT];
    assign wuck = ctrl_q[rtc_pkg::RTC_C_WUCK +: 3];
    assign time_w = {9'h000, cal_bus.pm, cal_bus.hour, 1'b0,
                     cal_bus.min, 1'b0, cal_bus.sec};
    assign date_w = {8'h00, cal_bus.year, cal_bus.wday,
                     cal_bus.month, 2'b00, cal_bus.date};

    rtc_cal u_cal (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .fmt12(ctrl_q[rtc_pkg::RTC_C_FMT12]),
        .ld_time(ld_time),
        .ld_date(ld_date),
        .wdata(pwdata),
        .c(cal_bus.cal)
    );

    rtc_bkp_mem u_bkp (
        .pclk(pclk),
        .we(wr & is_bkp(paddr)),
        .addr(paddr[6:2]),
        .wdata(pwdata),
        .rdata(bkp_rdata)
    );

    // ------------------------------------------------------------
    // timebase: source select, calibration, prescalers, wakeup
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] wm;
        logic [5:0] rtop;
        wm = 4'h0;
        rtop = ctrl_q[rtc_pkg::RTC_C_REF60] ? rtc_pkg::RTC_REF_60HZ
                                            : rtc_pkg::RTC_REF_50HZ;
        hdiv_d = hdiv_q + {4'h0, high_speed_crystal_clock_tick};
        case (rtc_pkg::rtc_cksel_t'(ctrl_q[rtc_pkg::RTC_C_CKSEL +: 2]))
            rtc_pkg::RTC_CK_LSXTAL: src = low_speed_crystal_clock_tick;
            rtc_pkg::RTC_CK_LSRC: src = low_speed_rc_clock_tick;
            rtc_pkg::RTC_CK_HSXTAL: src = high_speed_crystal_clock_tick
                & (hdiv_q == rtc_pkg::RTC_HSE_DIV_MAX); // R11
            default: src = 1'b0;
        endcase
        // only the crystal keeps running on battery and in shutdown
        run = (ctrl_q[rtc_pkg::RTC_C_CKSEL +: 2] == 2'(rtc_pkg::RTC_CK_LSXTAL))
              | (~on_battery & ~in_shutdown); // R12
        p = src & run & ~ctrl_q[rtc_pkg::RTC_C_INIT];
        win_d = win_q + {19'h0, p};
        drop_cal = (win_q < {11'h000, calm_q}); // R5
        shift_take = p & ~drop_cal & (shift_q != 15'h0000); // R3
        eff = p & ~drop_cal & ~shift_take;
        a_d = a_q;
        sp_d = sp_q;
        if (eff) begin
            a_d = (a_q == rtc_pkg::RTC_APRE_MAX) ? 7'h00 : a_q + 7'h01;
            if (a_q == rtc_pkg::RTC_APRE_MAX) begin
                sp_d = (sp_q == rtc_pkg::RTC_SPRE_MAX) ? 8'h00 : sp_q + 8'h01;
            end
        end
        rcnt_d = rcnt_q;
        ref_sec = 1'b0;
        if (ctrl_q[rtc_pkg::RTC_C_REFON] && ref_in && !ref_p_q) begin
            rcnt_d = rcnt_q + 6'h01;
            if (rcnt_q == rtop - 6'h01) begin
                rcnt_d = 6'h00; // R4
                ref_sec = 1'b1;
                a_d = 7'h00;
                sp_d = 8'h00;
            end
        end
        // with the reference on, drift of the crystal cannot accumulate
        tick = ctrl_q[rtc_pkg::RTC_C_REFON] ? ref_sec
             : eff & (a_q == rtc_pkg::RTC_APRE_MAX)
                   & (sp_q == rtc_pkg::RTC_SPRE_MAX); // R4
        case (wuck[1:0])
            2'h1: wm = 4'h8;
            2'h2: wm = 4'hc;
            2'h3: wm = 4'he;
            default: wm = 4'h0;
        endcase
        wu_base = wuck[2] ? tick : eff & ((a_q[3:0] | wm) == 4'hf); // R8
        ev = 7'h00;
        wu_d = wu_q;
        if (!ctrl_q[rtc_pkg::RTC_C_WUTEN]) begin
            wu_d = {wuck[2] & wuck[1], wutr_q}; // R8
        end else if (wu_base) begin
            wu_d = wu_q - 17'h00001;
            if (wu_q == 17'h00000) begin
                wu_d = {wuck[2] & wuck[1], wutr_q}; // R8
                ev[rtc_pkg::RTC_S_WUT] = 1'b1;
            end
        end
        hit_d = {alarm_hit(alrb_q, time_w | {2'b00, date_w[5:0], 24'h0}),
                 alarm_hit(alra_q, time_w | {2'b00, date_w[5:0], 24'h0})};
        ev[rtc_pkg::RTC_S_ALRA] = hit_d[0] & ~hit_q[0]
                                & ctrl_q[rtc_pkg::RTC_C_ALRAEN]; // R14
        ev[rtc_pkg::RTC_S_ALRB] = hit_d[1] & ~hit_q[1]
                                & ctrl_q[rtc_pkg::RTC_C_ALRBEN]; // R14
        samp = eff & (a_q == rtc_pkg::RTC_APRE_MAX);
        ev[rtc_pkg::RTC_S_TAMP +: 3] = tamp_ev;
        ts_ev = ctrl_q[rtc_pkg::RTC_C_TSEN]
                & ((ts_in & ~ts_p_q) | (on_battery & ~bat_p_q)
                   | (ctrl_q[rtc_pkg::RTC_C_TAMPTS] & (|tamp_ev))); // R7
        ev[rtc_pkg::RTC_S_TS] = ts_ev;
        ssr = rtc_pkg::RTC_SPRE_MAX - sp_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdiv_q <= 5'h00;
            a_q <= 7'h00;
            sp_q <= 8'h00;
            win_q <= 20'h00000;
            rcnt_q <= 6'h00;
            wu_q <= 17'h00000;
            hit_q <= 2'h0;
            {ref_p_q, ts_p_q, bat_p_q} <= 3'h0;
        end else begin
            hdiv_q <= hdiv_d;
            a_q <= a_d;
            sp_q <= sp_d;
            win_q <= win_d;
            rcnt_q <= rcnt_d;
            wu_q <= wu_d;
            hit_q <= hit_d;
            {ref_p_q, ts_p_q, bat_p_q} <= {ref_in, ts_in, on_battery};
        end
    end

    // ------------------------------------------------------------
    // tamper filters
    // ------------------------------------------------------------
    for (genvar i = 0; i < rtc_pkg::RTC_NUM_TAMP; i++) begin : g_tamp
        logic [3:0] cnt_q, cnt_d, need;
        logic prev_q;
        always_comb begin
            need = 4'(4'h1 << ctrl_q[rtc_pkg::RTC_C_TAMPFLT +: 2]);
            cnt_d = cnt_q;
            tamp_ev[i] = 1'b0;
            if (ctrl_q[rtc_pkg::RTC_C_TAMPFLT +: 2] == 2'h0) begin
                tamp_ev[i] = tamper_in[i] & ~prev_q; // R6
            end else if (samp) begin
                cnt_d = tamper_in[i] ? cnt_q + 4'h1 : 4'h0;
                if (cnt_q == need) begin
                    cnt_d = need;
                end
                tamp_ev[i] = tamper_in[i] & (cnt_q + 4'h1 == need); // R6
            end
            tamp_ev[i] = tamp_ev[i] & ctrl_q[rtc_pkg::RTC_C_TAMPEN + i];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q <= 4'h0;
                prev_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                prev_q <= tamper_in[i];
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        {ctrl_d, alra_d, alrb_d, calm_d, wutr_d} =
            {ctrl_q, alra_q, alrb_q, calm_q, wutr_q};
        {tst_d, tsd_d, tss_d, mask_d} = {tst_q, tsd_q, tss_q, mask_q};
        shift_d = shift_take ? shift_q - 15'h0001 : shift_q;
        st_d = st_q;
        if (wr) begin
            case (paddr)
                rtc_pkg::RTC_CTRL: ctrl_d = pwdata;
                rtc_pkg::RTC_SHIFT: shift_d = pwdata[14:0]; // R3
                rtc_pkg::RTC_CAL: calm_d = pwdata[8:0]; // R5
                rtc_pkg::RTC_WUTR: wutr_d = pwdata[15:0];
                rtc_pkg::RTC_ALRA: alra_d = pwdata;
                rtc_pkg::RTC_ALRB: alrb_d = pwdata;
                rtc_pkg::RTC_STAT: st_d = st_q & ~pwdata[6:0];
                rtc_pkg::RTC_MASK: mask_d = pwdata[6:0];
                default: ;
            endcase
        end
        st_d = st_d | ev; // R13
        if (ts_ev) begin
            {tst_d, tsd_d, tss_d} = {time_w, date_w, ssr}; // R7
        end
        err_d = err_q;
        bkp_rd_d = bkp_rd_q;
        prdata_d = prdata_q;
        if (setup) begin
            err_d = 1'b0;
            bkp_rd_d = is_bkp(paddr);
            case (paddr)
                rtc_pkg::RTC_TIME: prdata_d = time_w;
                rtc_pkg::RTC_DATE: prdata_d = date_w;
                rtc_pkg::RTC_CTRL: prdata_d = ctrl_q;
                rtc_pkg::RTC_SSR: prdata_d = {24'h0, ssr};
                rtc_pkg::RTC_SHIFT: prdata_d = {17'h0, shift_q};
                rtc_pkg::RTC_CAL: prdata_d = {23'h0, calm_q};
                rtc_pkg::RTC_WUTR: prdata_d = {16'h0, wutr_q};
                rtc_pkg::RTC_ALRA: prdata_d = alra_q;
                rtc_pkg::RTC_ALRB: prdata_d = alrb_q;
                rtc_pkg::RTC_TSTIME: prdata_d = tst_q;
                rtc_pkg::RTC_TSDATE: prdata_d = tsd_q;
                rtc_pkg::RTC_TSSSR: prdata_d = {24'h0, tss_q};
                rtc_pkg::RTC_STAT: prdata_d = {25'h0, st_q};
                rtc_pkg::RTC_MASK: prdata_d = {25'h0, mask_q};
                default: begin
                    prdata_d = 32'h0000_0000;
                    err_d = ~is_bkp(paddr);
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= rtc_pkg::RTC_CTRL_RST;
            {alra_q, alrb_q, tst_q, tsd_q} <= {4{32'h0000_0000}};
            tss_q <= 8'h00;
            shift_q <= 15'h0000;
            calm_q <= 9'h000;
            wutr_q <= 16'h0000;
            st_q <= 7'h00;
            mask_q <= 7'h00;
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            bkp_rd_q <= 1'b0;
        end else begin
            {ctrl_q, alra_q, alrb_q, tst_q, tsd_q} <=
                {ctrl_d, alra_d, alrb_d, tst_d, tsd_d};
            {tss_q, shift_q, calm_q, wutr_q} <=
                {tss_d, shift_d, calm_d, wutr_d};
            {st_q, mask_q, prdata_q, err_q, bkp_rd_q} <=
                {st_d, mask_d, prdata_d, err_d, bkp_rd_d};
        end
    end

    assign prdata = bkp_rd_q ? bkp_rdata : prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_q;
    assign irq = |(st_q & mask_q); // R13
    assign wakeup_req = |(st_q & mask_q); // R13
endmodule

/* rtc_top_sva.sv */
`timescale 1ns/1ps
module rtc_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic wakeup_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire rd = acc && !pwrite;
    wire hole = paddr inside {[12'h038:12'h0fc]};
    chk_irq_wake_same: assert property (irq == wakeup_req)
        else $error("irq and wakeup request differ");
    chk_irq_after_rst: assert property ($rose(presetn) |-> !irq)
        else $error("irq high right after reset");
    chk_ready_access: assert property (acc |-> pready)
        else $error("access not answered at once");
    chk_err_hole: assert property (acc && hole |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (acc && paddr < 12'h038 |-> !pslverr)
        else $error("mapped access flagged as error");
    chk_hole_zero: assert property (rd && hole |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_rd_hold: assert property (rd ##1 !psel |-> $stable(prdata))
        else $error("read data moved after access");
    chk_time_bcd: assert property (rd && paddr == 12'h000 |->
        prdata[3:0] < 10 && prdata[6:4] < 6 && prdata[11:8] < 10)
        else $error("time not in bcd");
    chk_date_bcd: assert property (rd && paddr == 12'h004 |->
        prdata[5:0] != 0 && prdata[3:0] < 10 && prdata[12:8] != 0)
        else $error("date not in bcd");
endmodule
bind rtc_top rtc_top_sva rtc_top_sva_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq,
    .wakeup_req);

/* rtc_xtal_model.sv */
`timescale 1ns/1ps
// one pulse per crystal period; every clock here to keep runs short
module rtc_xtal_model (
    input wire logic pclk,
    input wire logic run,
    output logic tick
);
    initial tick = 1'b0;
    // not gated by battery or shutdown: the crystal keeps going
    always @(posedge pclk) begin
        tick <= run;
    end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wk;
    logic xt_run, xt_tick, rc_tick, hs_tick, on_battery, ts_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, e;
    logic [2:0] tamper_in;
    int errors, checks, d, m, y;
    logic [31:0] bk[$];
    rtc_xtal_model rtc_xtal_model_inst (.pclk(pclk), .run(xt_run),
        .tick(xt_tick));
    rtc_top rtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_crystal_clock_tick(xt_tick),
        .low_speed_rc_clock_tick(rc_tick),
        .high_speed_crystal_clock_tick(hs_tick), .on_battery(on_battery),
        .in_shutdown(1'b0), .ref_in(1'b0), .ts_in(ts_in),
        .tamper_in(tamper_in), .irq(irq), .wakeup_req(wk));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        rc_tick <= 1'($urandom);
        hs_tick <= 1'($urandom);
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for pready at an edge, bounded
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            tally_and_finish;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] bcd(input int x);
        return 32'(((x / 10) << 4) | (x % 10));
    endfunction
    function automatic int mlen(input int mm, input int yy);
        if (mm == 2) return (yy % 4 == 0) ? 29 : 28;
        return (mm == 4 || mm == 6 || mm == 9 || mm == 11) ? 30 : 31;
    endfunction
    initial begin
        #400000;
        errors++;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        q = $urandom(32'hc897);
        {presetn, psel, penable, pwrite, xt_run, on_battery, ts_in} = 0;
        {tamper_in, paddr, pwdata} = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            bk.push_back($urandom);
            apb(1'b1, 12'h100 + 12'(4 * i), bk[i], q);
        end
        @(posedge pclk) presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            apb(1'b0, 12'h100 + 12'(4 * i), 32'h0, q);
            cmp("backup", bk[i], q);
        end
        apb(1'b0, rtc_pkg::RTC_DATE, 32'h0, q);
        cmp("date reset", rtc_pkg::RTC_DATE_RST, q);
        apb(1'b0, 12'h080, 32'h0, q);
        cmp("unmapped", 32'h0, q);
        $display("test backup done");
        // seconds field left out: prescaler phase at init exit is free
        xt_run <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            d = 28;
            m = 2;
            y = 23 + k;
            apb(1'b1, rtc_pkg::RTC_CTRL, 32'h1, q);
            apb(1'b1, rtc_pkg::RTC_TIME, 32'h0023_5959, q);
            apb(1'b1, rtc_pkg::RTC_DATE, (bcd(y) << 16) | 32'h0228, q);
            apb(1'b1, rtc_pkg::RTC_CTRL, 32'h0, q);
            repeat (33000) @(posedge pclk);
            d++;
            if (d > mlen(m, y)) begin
                d = 1;
                m++;
            end
            apb(1'b0, rtc_pkg::RTC_TIME, 32'h0, q);
            cmp("time", 32'h0, q & 32'h007f_7f00);
            apb(1'b0, rtc_pkg::RTC_DATE, 32'h0, q);
            e = (bcd(y) << 16) | (bcd(m) << 8) | bcd(d);
            cmp("date", e, q & 32'h00ff_1f3f);
        end
        $display("test calendar done");
        apb(1'b1, rtc_pkg::RTC_CTRL, 32'h0001_c400, q);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, rtc_pkg::RTC_MASK, 32'h0, q);
            ts_in <= (k == 0);
            on_battery <= (k == 1);
            tamper_in <= (k > 1) ? 3'(1 << (k - 2)) : 3'h0;
            repeat (4) @(posedge pclk);
            e = (k < 2) ? 32'h8 : 32'(1 << (k + 2));
            apb(1'b0, rtc_pkg::RTC_STAT, 32'h0, q);
            cmp("status", e, q & 32'h7f);
            cmp("masked irq", 32'h0, {30'h0, irq, wk});
            apb(1'b1, rtc_pkg::RTC_MASK, e, q);
            @(posedge pclk);
            cmp("irq", 32'h3, {30'h0, irq, wk});
            apb(1'b1, rtc_pkg::RTC_STAT, e, q);
            @(posedge pclk);
            cmp("irq clear", 32'h0, {30'h0, irq, wk});
        end
        apb(1'b0, rtc_pkg::RTC_TSDATE, 32'h0, q);
        e = (bcd(y) << 16) | (bcd(m) << 8) | bcd(d);
        cmp("stamp date", e, q & 32'h00ff_1f3f);
        $display("test events done");
        apb(1'b1, rtc_pkg::RTC_WUTR, 32'h1, q);
        apb(1'b1, rtc_pkg::RTC_CTRL, 32'h2070, q);
        repeat (400) @(posedge pclk);
        apb(1'b0, rtc_pkg::RTC_STAT, 32'h0, q);
        cmp("wakeup", 32'h4, q & 32'h4);
        $display("test wakeup done");
        tally_and_finish;
    end
endmodule
